// ---- rtl/timer_pkg.sv ----
// Purpose: Constants, types and state layout of the 8-bit compare timer
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes:   Shared by the timer core and the testbench
package timer_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFF_CONTROL    = 8'h00;
   localparam logic [7:0] OFF_COUNTER    = 8'h04;
   localparam logic [7:0] OFF_COMPARE    = 8'h08;
   localparam logic [7:0] OFF_ASYNC      = 8'h0C;
   localparam logic [7:0] OFF_INT_STATUS = 8'h10;
   localparam logic [7:0] OFF_INT_CLEAR  = 8'h14;
   localparam logic [7:0] OFF_INT_ENABLE = 8'h18;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTL_FORCE  = 7;
   localparam int CTL_WGM_LO = 6;
   localparam int CTL_COM_HI = 5;
   localparam int CTL_COM_LO = 4;
   localparam int CTL_WGM_HI = 3;
   localparam int CTL_CS_HI  = 2;
   localparam int AS_SEL     = 3;
   localparam int B_CNT      = 2;
   localparam int B_CMP      = 1;
   localparam int B_CTL      = 0;
   localparam int INT_OVF    = 0;
   localparam int INT_CMP    = 1;

   ////////////////////////////////////////////////////////////////////////
   // Values
   localparam logic [7:0] COUNT_MAX    = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   localparam logic [1:0] COM_OFF      = 2'h0;
   localparam logic [1:0] COM_TOGGLE   = 2'h1;
   localparam logic [1:0] COM_CLEAR    = 2'h2;
   localparam logic [1:0] COM_SET      = 2'h3;
   localparam logic [2:0] CS_STOP      = 3'h0;

   typedef enum logic [1:0] {
      WM_NORMAL = 2'b00,
      WM_PHASE  = 2'b01,
      WM_CTC    = 2'b10,
      WM_FAST   = 2'b11
   } wave_mode_e;

   // Prescaler tap mask per clock select code
   function automatic logic [9:0] div_mask(input logic [2:0] cs);
      case (cs)
         3'h2:    div_mask = 10'h007;
         3'h3:    div_mask = 10'h01F;
         3'h4:    div_mask = 10'h03F;
         3'h5:    div_mask = 10'h07F;
         3'h6:    div_mask = 10'h0FF;
         3'h7:    div_mask = 10'h3FF;
         default: div_mask = 10'h000;
      endcase
   endfunction

   typedef struct packed {
      logic        osc_meta;
      logic        osc_sync;
      logic        osc_prev;
      logic [9:0]  presc;
      logic        async_sel;
      logic [7:0]  ctl_tmp;
      logic [7:0]  ctl;
      logic [7:0]  cmp_tmp;
      logic [7:0]  cmp;
      logic [7:0]  cnt_tmp;
      logic [7:0]  cnt;
      logic [2:0]  busy;
      logic [2:0]  edge_seen;
      logic        dir_down;
      logic        blocked;
      logic        oc;
      logic [1:0]  int_stat;
      logic [1:0]  int_en;
      logic [31:0] rdata;
   } state_s;

endpackage

// ---- rtl/compare_timer.sv ----
// Purpose: 8-bit timer with one compare channel, prescaler and async mode
// Assumes: APB slave, oscillator pin sampled into the I/O clock
// Notes:   Oscillator must be well under a quarter of clock_i
//
// Functional notes
// - Nonzero output mode drives pin; driver enabled only with direction bit set.
// - Non-PWM: mode 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM: 2 clears on match sets at bottom; 3 inverse.
// - Fast PWM, compare at top, upper bit set: ignore match, bottom action stays.
// - Phase correct: 2 clears on up match, sets on down match; 3 inverse.
// - Phase correct, compare at top, upper bit set: act at top instead.
// - Clock select: stop, undivided, then divide by 8,32,64,128,256,1024.
// - Counter readable live and writable by software.
// - Counter write suppresses compare match on next timer clock.
// - Compare equality raises match interrupt and drives waveform.
// - Async select low uses I/O clock, high uses oscillator pin.
// - Switching clock source may corrupt registers; software rewrites them.
// - Async counter write sets busy until transferred.
// - Async compare write sets busy until transferred.
// - Async control write sets busy until transferred.
// - Each register has own temporary, loaded after two oscillator edges.
// - Compare and control read temporaries; counter reads live value.
`timescale 1ns/100ps
`default_nettype none
module compare_timer
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // APB
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic [31:0]      prdata_o,
   // Pins
   input  wire logic        timer_osc_input_i,
   input  wire logic        port_dir_i,
   output logic             compare_output_pin_o,
   output logic             compare_output_pin_oe_o,
   // Interrupt
   output logic             irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // State
   state_s     s_reg;
   state_s     s_next;
   wave_mode_e mode;
   logic [1:0] com;
   logic [2:0] cs;
   logic       osc_edge;
   logic       src_tick;
   logic       tick;
   logic       match;
   logic       ignore_top;
   logic       wr;
   logic       setup;
   logic       mapped;
   logic       cnt_load;

   assign mode       = wave_mode_e'({s_reg.ctl[CTL_WGM_HI], s_reg.ctl[CTL_WGM_LO]});
   assign com        = s_reg.ctl[CTL_COM_HI:CTL_COM_LO];
   assign cs         = s_reg.ctl[CTL_CS_HI:0];
   assign osc_edge   = s_reg.osc_sync & ~s_reg.osc_prev;
   assign src_tick   = s_reg.async_sel ? osc_edge : 1'b1;
   assign tick       = src_tick && (cs != CS_STOP)
                       && ((s_reg.presc & div_mask(cs)) == div_mask(cs));
   assign match      = tick && (s_reg.cnt == s_reg.cmp) && !s_reg.blocked;
   assign ignore_top = (s_reg.cmp == COUNT_MAX) && com[1];
   assign wr         = psel_i && penable_i && pwrite_i;
   assign setup      = psel_i && !penable_i;
   assign mapped     = (paddr_i <= OFF_INT_ENABLE) && (paddr_i[1:0] == 2'h0);

   ////////////////////////////////////////////////////////////////////////
   // Bus answers
   assign pready_o                = 1'b1;
   assign pslverr_o               = psel_i && penable_i && !mapped;
   assign prdata_o                = s_reg.rdata;
   assign compare_output_pin_o    = s_reg.oc;
   assign compare_output_pin_oe_o = (com != COM_OFF) && port_dir_i;
   assign irq_o                   = |(s_reg.int_stat & s_reg.int_en);

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_next   = s_reg;
      cnt_load = 1'b0;
      // Pin synchroniser, then edge history
      s_next.osc_meta = timer_osc_input_i;
      s_next.osc_sync = s_reg.osc_meta;
      s_next.osc_prev = s_reg.osc_sync;
      if (src_tick) begin
         s_next.presc = s_reg.presc + 10'h001;
      end

      // Counting sequence
      if (tick) begin
         s_next.blocked = 1'b0;
         unique case (mode)
            WM_NORMAL, WM_FAST: begin
               s_next.cnt = s_reg.cnt + 8'h01;
               if (s_reg.cnt == COUNT_MAX) begin
                  s_next.int_stat[INT_OVF] = 1'b1;
               end
            end
            WM_CTC: begin
               s_next.cnt = (s_reg.cnt == s_reg.cmp) ? COUNT_BOTTOM : s_reg.cnt + 8'h01;
               if (s_reg.cnt == COUNT_MAX) begin
                  s_next.int_stat[INT_OVF] = 1'b1;
               end
            end
            WM_PHASE: begin
               if (!s_reg.dir_down) begin
                  if (s_reg.cnt == COUNT_MAX) begin
                     s_next.dir_down = 1'b1;
                     s_next.cnt      = s_reg.cnt - 8'h01;
                  end else begin
                     s_next.cnt = s_reg.cnt + 8'h01;
                  end
               end else if (s_reg.cnt == COUNT_BOTTOM) begin
                  s_next.dir_down          = 1'b0;
                  s_next.cnt               = s_reg.cnt + 8'h01;
                  s_next.int_stat[INT_OVF] = 1'b1;
               end else begin
                  s_next.cnt = s_reg.cnt - 8'h01;
               end
            end
         endcase
      end

      // Waveform actions
      if (match) begin
         s_next.int_stat[INT_CMP] = 1'b1;
      end
      unique case (mode)
         WM_NORMAL, WM_CTC: begin
            if (match) begin
               case (com)
                  COM_TOGGLE: s_next.oc = ~s_reg.oc;
                  COM_CLEAR:  s_next.oc = 1'b0;
                  COM_SET:    s_next.oc = 1'b1;
                  default:    s_next.oc = s_reg.oc;
               endcase
            end
         end
         WM_FAST: begin
            if (com[1]) begin
               if (match && !ignore_top) begin
                  s_next.oc = (com == COM_SET);
               end
               if (tick && s_reg.cnt == COUNT_MAX) begin
                  s_next.oc = (com == COM_CLEAR);
               end
            end
         end
         WM_PHASE: begin
            if (com[1]) begin
               if (match && !ignore_top) begin
                  s_next.oc = s_reg.dir_down ? (com == COM_CLEAR) : (com == COM_SET);
               end
               if (ignore_top && tick && s_reg.cnt == COUNT_MAX && !s_reg.dir_down) begin
                  s_next.oc = (com == COM_CLEAR);
               end
            end
         end
      endcase

      // Temporary to destination transfers, two oscillator edges each
      if (osc_edge) begin
         for (int i = 0; i < 3; i++) begin
            if (s_reg.busy[i]) begin
               if (s_reg.edge_seen[i]) begin
                  s_next.busy[i]      = 1'b0;
                  s_next.edge_seen[i] = 1'b0;
                  if (i == B_CNT) begin
                     s_next.cnt = s_reg.cnt_tmp;
                     cnt_load   = 1'b1;
                  end else if (i == B_CMP) begin
                     s_next.cmp = s_reg.cmp_tmp;
                  end else begin
                     s_next.ctl = s_reg.ctl_tmp;
                  end
               end else begin
                  s_next.edge_seen[i] = 1'b1;
               end
            end
         end
      end

      // Register writes
      if (wr) begin
         unique case (paddr_i)
            OFF_CONTROL: begin
               s_next.ctl_tmp            = pwdata_i[7:0];
               s_next.ctl_tmp[CTL_FORCE] = 1'b0;
               if (s_reg.async_sel) begin
                  s_next.busy[B_CTL]      = 1'b1;
                  s_next.edge_seen[B_CTL] = 1'b0;
               end else begin
                  s_next.ctl            = pwdata_i[7:0];
                  s_next.ctl[CTL_FORCE] = 1'b0;
               end
            end
            OFF_COUNTER: begin
               s_next.cnt_tmp = pwdata_i[7:0];
               if (s_reg.async_sel) begin
                  s_next.busy[B_CNT]      = 1'b1;
                  s_next.edge_seen[B_CNT] = 1'b0;
               end else begin
                  s_next.cnt = pwdata_i[7:0];
                  cnt_load   = 1'b1;
               end
            end
            OFF_COMPARE: begin
               s_next.cmp_tmp = pwdata_i[7:0];
               if (s_reg.async_sel) begin
                  s_next.busy[B_CMP]      = 1'b1;
                  s_next.edge_seen[B_CMP] = 1'b0;
               end else begin
                  s_next.cmp = pwdata_i[7:0];
               end
            end
            OFF_ASYNC: begin
               s_next.async_sel = pwdata_i[AS_SEL];
            end
            OFF_INT_CLEAR: begin
               s_next.int_stat = s_next.int_stat & ~(pwdata_i[1:0] & ~s_next.int_stat
                                 | pwdata_i[1:0]) | (s_next.int_stat & ~s_reg.int_stat);
            end
            OFF_INT_ENABLE: begin
               s_next.int_en = pwdata_i[1:0];
            end
            default: begin
               s_next.int_en = s_reg.int_en;
            end
         endcase
      end
      if (cnt_load) begin
         s_next.blocked = 1'b1;
      end

      // Read data captured in setup phase
      if (setup) begin
         unique case (paddr_i)
            OFF_CONTROL:    s_next.rdata = {24'h000000, s_reg.ctl_tmp};
            OFF_COUNTER:    s_next.rdata = {24'h000000, s_reg.cnt};
            OFF_COMPARE:    s_next.rdata = {24'h000000, s_reg.cmp_tmp};
            OFF_ASYNC:      s_next.rdata = {28'h0000000, s_reg.async_sel, s_reg.busy};
            OFF_INT_STATUS: s_next.rdata = {30'h0, s_reg.int_stat};
            OFF_INT_ENABLE: s_next.rdata = {30'h0, s_reg.int_en};
            default:        s_next.rdata = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else if (ce_i) begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence wr_cnt_async;
      ce_i && wr && paddr_i == OFF_COUNTER && s_reg.async_sel;
   endsequence

   sequence wr_cmp_async;
      ce_i && wr && paddr_i == OFF_COMPARE && s_reg.async_sel;
   endsequence

   sequence wr_ctl_async;
      ce_i && wr && paddr_i == OFF_CONTROL && s_reg.async_sel;
   endsequence

   sequence non_pwm_match;
      ce_i && match && (mode == WM_NORMAL || mode == WM_CTC);
   endsequence

   a_pin_drive: assert property (
      compare_output_pin_oe_o == ((com != COM_OFF) && port_dir_i))
      else $error("pin enable wrong");
   a_toggle_match: assert property (
      ce_i && match && com == COM_TOGGLE && mode == WM_NORMAL |=> s_reg.oc != $past(s_reg.oc))
      else $error("toggle missing");
   a_fast_bottom: assert property (
      ce_i && mode == WM_FAST && com == COM_CLEAR && tick && s_reg.cnt == COUNT_MAX
      |=> s_reg.oc)
      else $error("bottom set missing");
   a_fast_top_ignore: assert property (
      ce_i && mode == WM_FAST && com == COM_SET && ignore_top && tick && s_reg.cnt == COUNT_MAX
      |=> !s_reg.oc)
      else $error("top match not ignored");
   a_phase_up: assert property (
      ce_i && mode == WM_PHASE && com == COM_CLEAR && match && !ignore_top && !s_reg.dir_down
      |=> !s_reg.oc)
      else $error("up match not cleared");
   a_phase_top: assert property (
      ce_i && mode == WM_PHASE && com == COM_CLEAR && ignore_top && tick
      && s_reg.cnt == COUNT_MAX && !s_reg.dir_down |=> s_reg.oc)
      else $error("top action missing");
   a_clock_stop: assert property (cs == CS_STOP |-> !tick)
      else $error("stopped timer ticked");
   a_div_eight: assert property (tick && cs == 3'h2 |-> s_reg.presc[2:0] == 3'h7)
      else $error("divide by 8 wrong");
   a_load_block: assert property (
      ce_i && cnt_load |=> s_reg.blocked && !match)
      else $error("match not blocked");
   a_match_flag: assert property (ce_i && match |=> s_reg.int_stat[INT_CMP])
      else $error("match flag missing");
   a_cnt_busy: assert property (wr_cnt_async |=> s_reg.busy[B_CNT] ##0 !$past(cnt_load))
      else $error("counter busy missing");
   a_cmp_busy: assert property (wr_cmp_async |=> s_reg.busy[B_CMP])
      else $error("compare busy missing");
   a_cmp_transfer: assert property (
      $fell(s_reg.busy[B_CMP]) && !$past(wr) |-> s_reg.cmp == $past(s_reg.cmp_tmp))
      else $error("compare not loaded");
   a_ctl_transfer: assert property (
      $fell(s_reg.busy[B_CTL]) && !$past(wr) |-> s_reg.ctl == $past(s_reg.ctl_tmp))
      else $error("control not loaded");

   // Further waveform, clocking, transfer, flag, freeze and read checks
   a_match_set: assert property (non_pwm_match ##0 com == COM_SET |=> s_reg.oc)
      else $error("set on match missing");
   a_match_clear: assert property (non_pwm_match ##0 com == COM_CLEAR |=> !s_reg.oc)
      else $error("clear on match missing");
   a_ctc_wrap: assert property (
      non_pwm_match ##0 mode == WM_CTC && !cnt_load |=> s_reg.cnt == COUNT_BOTTOM)
      else $error("clear on match count wrong");
   a_fast_match: assert property (
      ce_i && mode == WM_FAST && com == COM_CLEAR && match && !ignore_top |=> !s_reg.oc)
      else $error("fast match not cleared");
   a_phase_down: assert property (
      ce_i && mode == WM_PHASE && com == COM_CLEAR && match && !ignore_top && s_reg.dir_down
      |=> s_reg.oc)
      else $error("down match not set");
   a_async_source: assert property (s_reg.async_sel && !osc_edge |-> !tick)
      else $error("tick without oscillator edge");
   a_div_top: assert property (tick && cs == 3'h7 |-> &s_reg.presc)
      else $error("divide by 1024 wrong");
   a_cnt_transfer: assert property (
      $fell(s_reg.busy[B_CNT]) && !$past(wr) |-> s_reg.cnt == $past(s_reg.cnt_tmp) && s_reg.blocked)
      else $error("counter not loaded");
   a_ctl_busy: assert property (wr_ctl_async |=> s_reg.busy[B_CTL])
      else $error("control busy missing");
   a_busy_hold: assert property (
      s_reg.busy[B_CMP] && !s_reg.edge_seen[B_CMP] |=> s_reg.busy[B_CMP])
      else $error("compare moved before two edges");
   a_read_live: assert property (
      ce_i && setup && paddr_i == OFF_COUNTER |=> prdata_o == {24'h000000, $past(s_reg.cnt)})
      else $error("counter read not live");
   a_read_temp: assert property (
      ce_i && setup && paddr_i == OFF_COMPARE |=> prdata_o == {24'h000000, $past(s_reg.cmp_tmp)})
      else $error("compare read not temporary");
   a_ovf_flag: assert property (
      ce_i && tick && mode == WM_NORMAL && s_reg.cnt == COUNT_MAX |=> s_reg.int_stat[INT_OVF])
      else $error("overflow flag missing");
   a_force_zero: assert property (!s_reg.ctl[CTL_FORCE] && !s_reg.ctl_tmp[CTL_FORCE])
      else $error("force bit stored");
   a_ce_freeze: assert property (!ce_i |=> s_reg == $past(s_reg))
      else $error("state moved with enable low");

endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the 8-bit compare timer
// Assumes: APB slave with no wait states, 100 MHz clock, free oscillator pin
// Notes:   Compare values and register data drawn from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module testbench
   import timer_pkg::*;
();
logic        clk = 1'b0;
logic        rst = 1'b1;
logic        osc = 1'b0;
logic        port_dir = 1'b1;
logic        ce = 1'b1;
logic        psel = 1'b0;
logic        penable = 1'b0;
logic        pwrite = 1'b0;
logic [7:0]  paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic        pready;
logic        pslverr;
logic [31:0] prdata;
logic        pin;
logic        oe;
logic        irq;
logic [31:0] rdat;
logic        rerr;
logic [31:0] r;
logic [7:0]  cmp;
logic [1:0]  com;
wave_mode_e  wm;
int          seed = 32'h6EDB4026;
int          error_cnt = 0;
int          tests_run = 0;
int          n;
int          e;
int          tol;
int          per;
logic [7:0]  offs [5] = '{OFF_CONTROL, OFF_COUNTER, OFF_COMPARE, OFF_ASYNC, OFF_INT_STATUS};
logic [7:0]  aoff [3] = '{OFF_COUNTER, OFF_COMPARE, OFF_CONTROL};
logic [7:0]  aval [3] = '{8'h00, 8'h33, 8'h01};
logic [7:0]  abit [3] = '{8'h04, 8'h02, 8'h01};
logic [1:0]  coms [3] = '{2'h3, 2'h2, 2'h1};
logic        pexp [3] = '{1'b1, 1'b0, 1'b1};

always #5 clk = ~clk;
// Oscillator pin toggles every ten clocks
always begin
   repeat (10) @(posedge clk);
   osc <= ~osc;
end

compare_timer dut_u (
   .clock_i(clk), .rst_i(rst), .ce_i(ce), .psel_i(psel), .penable_i(penable),
   .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
   .pslverr_o(pslverr), .prdata_o(prdata), .timer_osc_input_i(osc),
   .port_dir_i(port_dir), .compare_output_pin_o(pin),
   .compare_output_pin_oe_o(oe), .irq_o(irq)
);

////////////////////////////////////////////////////////////////////////////
function automatic int div_of(input int cs);
   case (cs)
      1:       div_of = 1;
      2:       div_of = 8;
      3:       div_of = 32;
      4:       div_of = 64;
      5:       div_of = 128;
      6:       div_of = 256;
      default: div_of = 1024;
   endcase
endfunction

function automatic logic [31:0] ctl_byte(input wave_mode_e w, input logic [1:0] c, input logic [2:0] cs);
   ctl_byte = {24'h0, 1'b0, w[0], c, w[1], cs};
endfunction

function automatic int exp_hi(input wave_mode_e w, input logic [1:0] c, input logic [7:0] v);
   int k;
   if (w == WM_FAST) begin
      k = (v == 8'hFF) ? 512 : 2 * (v + 1);
      exp_hi = c[0] ? 512 - k : k;
   end else begin
      k = 2 * v;
      exp_hi = c[0] ? 510 - k : k;
   end
endfunction

////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string m);
   tests_run++;
   if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s: got %h expected %h..%h", $time, m, got, lo, hi);
   end
endtask

task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
   @(posedge clk);
   psel   <= 1'b1;
   pwrite <= w;
   paddr  <= a;
   pwdata <= d;
   @(posedge clk);
   penable <= 1'b1;
   do begin
      @(posedge clk);
   end while (pready !== 1'b1);
   rdat = prdata;
   rerr = pslverr;
   psel    <= 1'b0;
   penable <= 1'b0;
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
   xfer(1'b1, a, d);
endtask

task automatic rdchk(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi, input string m);
   xfer(1'b0, a, 32'h0);
   chk(rdat, lo, hi, m);
endtask

task automatic end_of_test();
   $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
   if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
   end else begin
      $display("*** FAIL ***");
   end
   $finish;
endtask

////////////////////////////////////////////////////////////////////////////
initial begin
   #(10 * 80000);
   error_cnt++;
   end_of_test();
end

initial begin
   repeat (20) @(posedge clk);
   rst <= 1'b0;
   foreach (offs[i]) rdchk(offs[i], 0, 0, "reset value");
   xfer(1'b0, 8'h1C, 32'h0);
   chk(rerr, 1, 1, "unmapped error");
   chk(rdat, 0, 0, "unmapped data");
   r = $random(seed);
   wr(OFF_COMPARE, r);
   rdchk(OFF_COMPARE, {24'h0, r[7:0]}, {24'h0, r[7:0]}, "compare readback");
   wr(OFF_CONTROL, {24'h0, 1'b1, r[6:3], 3'h0});
   rdchk(OFF_CONTROL, {25'h0, r[6:3], 3'h0}, {25'h0, r[6:3], 3'h0}, "control readback");
   wr(OFF_COUNTER, 8'h55);
   repeat (50) @(posedge clk);
   rdchk(OFF_COUNTER, 8'h55, 8'h55, "stopped counter");
   for (int cs = 1; cs < 8; cs++) begin
      wr(OFF_CONTROL, 0);
      wr(OFF_COUNTER, 0);
      wr(OFF_CONTROL, cs);
      repeat (20 * div_of(cs)) @(posedge clk);
      rdchk(OFF_COUNTER, 19, 24, "prescaled count");
   end
   // Clock enable low freezes the running counter
   wr(OFF_CONTROL, 0);
   wr(OFF_COUNTER, 0);
   wr(OFF_CONTROL, 1);
   ce <= 1'b0;
   repeat (100) @(posedge clk);
   ce <= 1'b1;
   rdchk(OFF_COUNTER, 0, 3, "frozen counter");
   // Non-PWM pin actions on one match
   wr(OFF_COMPARE, 8'h40);
   foreach (coms[i]) begin
      wr(OFF_CONTROL, ctl_byte(WM_NORMAL, coms[i], 3'h0));
      wr(OFF_COUNTER, 0);
      wr(OFF_CONTROL, ctl_byte(WM_NORMAL, coms[i], 3'h1));
      repeat (80) @(posedge clk);
      chk(pin, pexp[i], pexp[i], "match action");
      chk(oe, 1, 1, "driver on");
   end
   port_dir <= 1'b0;
   @(posedge clk);
   @(posedge clk);
   chk(oe, 0, 0, "direction input");
   port_dir <= 1'b1;
   wr(OFF_CONTROL, 0);
   @(posedge clk);
   chk(oe, 0, 0, "mode zero disconnects");
   // Clear-on-match mode toggles once per compare plus one ticks
   wr(OFF_COMPARE, 8'h20);
   wr(OFF_COUNTER, 0);
   wr(OFF_CONTROL, ctl_byte(WM_CTC, COM_TOGGLE, 3'h1));
   repeat (100) @(posedge clk);
   n = 0;
   repeat (660) begin
      @(posedge clk);
      if (pin === 1'b1) n++;
   end
   chk(n, 330, 330, "toggle duty");
   rdchk(OFF_COUNTER, 0, 8'h20, "count below compare");
   wr(OFF_CONTROL, 0);
   // Load blocks the match on the next tick
   wr(OFF_COMPARE, 8'h10);
   wr(OFF_COUNTER, 0);
   wr(OFF_INT_CLEAR, 3);
   wr(OFF_INT_ENABLE, 0);
   wr(OFF_CONTROL, 1);
   wr(OFF_COUNTER, 8'h10);
   repeat (100) @(posedge clk);
   rdchk(OFF_INT_STATUS, 0, 0, "match after load");
   repeat (260) @(posedge clk);
   rdchk(OFF_INT_STATUS, 3, 3, "match and overflow flags");
   chk(irq, 0, 0, "masked interrupt");
   wr(OFF_INT_ENABLE, 2);
   @(posedge clk);
   chk(irq, 1, 1, "enabled interrupt");
   wr(OFF_INT_CLEAR, 2);
   @(posedge clk);
   chk(irq, 0, 0, "cleared interrupt");
   rdchk(OFF_INT_STATUS, 1, 1, "clear one flag");
   // PWM duty in both PWM modes, top value among them
   for (int k = 0; k < 8; k++) begin
      wm = k[2] ? WM_PHASE : WM_FAST;
      com = {1'b1, k[1]};
      r = $random(seed);
      cmp = k[0] ? 8'hFF : 8'h20 + {1'b0, r[6:0]};
      per = k[2] ? 510 : 512;
      wr(OFF_COMPARE, cmp);
      wr(OFF_CONTROL, ctl_byte(wm, com, 3'h1));
      repeat (600) @(posedge clk);
      n = 0;
      repeat (per) begin
         @(posedge clk);
         if (pin === 1'b1) n++;
      end
      e = exp_hi(wm, com, cmp);
      tol = (e == 0 || e == per) ? 0 : 3;
      chk(n, e - tol, e + tol, "pwm high time");
   end
   // Oscillator clocking with update handshakes
   wr(OFF_CONTROL, 0);
   wr(OFF_ASYNC, 8'h08);
   rdchk(OFF_ASYNC, 8'h08, 8'h08, "async select");
   for (int i = 0; i < 3; i++) begin
      wr(aoff[i], aval[i]);
      rdchk(OFF_ASYNC, 8'h08 | abit[i], 8'h08 | abit[i], "busy set");
      n = 0;
      do begin
         xfer(1'b0, OFF_ASYNC, 32'h0);
         n++;
      end while (rdat[2:0] !== 3'h0 && n < 100);
      chk(n, 4, 20, "busy release time");
   end
   rdchk(OFF_COMPARE, 8'h33, 8'h33, "async compare readback");
   repeat (400) @(posedge clk);
   rdchk(OFF_COUNTER, 19, 23, "oscillator count");
   end_of_test();
end

endmodule
`default_nettype wire
